// File: rtl/usb_event_error_reporting.sv
// Contract
// - Eight event enables, bits 7..0, reset zero
// - Bit 0 gates reset or detach
// - Errors reach request only with bit 1
// - Error flags sticky, write one clears
// - Bit 7: bit stuffing violation
// - Bit 6: invalid descriptor/buffer address
// - Bit 5: memory overflow/underflow or truncation
// - Bit 4: turnaround timeout after 16 bits
// - Bit 3: data not whole bytes
// - Bit 2: data CRC16 failure
// - Device: bit 1 token CRC5 failure
// - Host: bit 1 end-of-frame error
// - Bit 0: PID complement check fails
// - Eight error enables, matching flag positions
// - Status bits 7..4 endpoint number
// - Status bit 3 transmit direction
// - Status bit 2 odd bank
// - Four-entry status FIFO, clear flag advances
// - Bits 31..8 read zero
// - Summary error set by enabled errors only
`timescale 1ns/1ps
`default_nettype none
`include "usb_evt_consts.svh"

module usb_event_error_reporting (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_mode,
    input  wire logic [7:0]  event_pulse,
    input  wire logic        bitstuff_err,
    input  wire logic        bus_addr_err,
    input  wire logic        mem_access_err,
    input  wire logic        turnaround_timeout,
    input  wire logic        partial_byte_err,
    input  wire logic        data_crc_err,
    input  wire logic        token_crc_err,
    input  wire logic        frame_end_err,
    input  wire logic        pid_check_err,
    input  wire logic        trans_done,
    input  wire logic [3:0]  trans_endpoint,
    input  wire logic        trans_dir_tx,
    input  wire logic        trans_bank_odd,
    output logic             usb_irq_request,
    output logic             stat_fifo_full
);

    usb_evt_pkg::reg8_t       usb_event_enable;
    usb_evt_pkg::reg8_t       usb_error_enable;
    usb_evt_pkg::reg8_t       usb_error_flags;
    usb_evt_pkg::reg8_t       event_flags;
    usb_evt_pkg::reg8_t       err_set;
    usb_evt_pkg::reg8_t       evt_set;
    usb_evt_pkg::reg8_t       err_clr;
    usb_evt_pkg::reg8_t       evt_clr;
    usb_evt_pkg::stat_entry_t fifo_mem [`STAT_FIFO_DEPTH];
    logic [1:0]               rd_ptr;
    logic [1:0]               wr_ptr;
    logic [2:0]               fifo_count;
    logic                     access;
    logic                     wr_en;
    logic                     byte0_wr;
    logic                     fifo_push;
    logic                     fifo_pop;
    logic                     addr_ok;
    logic [7:0]               rd_byte;
    logic [7:0]               next_irq_terms;

    assign access   = psel && penable;
    assign wr_en    = access && pwrite;
    assign byte0_wr = wr_en && pstrb[0];

    always_comb begin
        addr_ok = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            `OFS_EVENT_ENABLE: rd_byte = usb_event_enable;
            `OFS_ERROR_FLAGS:  rd_byte = usb_error_flags;
            `OFS_ERROR_ENABLE: rd_byte = usb_error_enable;
            `OFS_TRANS_STATUS: begin
                rd_byte = {fifo_mem[rd_ptr].endpoint,
                           fifo_mem[rd_ptr].dir_tx,
                           fifo_mem[rd_ptr].bank_odd, 2'b00};
            end
            `OFS_EVENT_FLAGS:  rd_byte = event_flags;
            default:           addr_ok = 1'b0;
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= {24'h00_0000, (psel && !pwrite) ? rd_byte : 8'h00};
        end
    end

    logic write_phase;
    assign write_phase = byte0_wr && pready;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            usb_event_enable <= `REG_RESET;
        end else if (write_phase && paddr == `OFS_EVENT_ENABLE) begin
            usb_event_enable <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            usb_error_enable <= `REG_RESET;
        end else if (write_phase && paddr == `OFS_ERROR_ENABLE) begin
            usb_error_enable <= pwdata[7:0];
        end
    end

    always_comb begin
        err_set = 8'h00;
        err_set[`ERR_BITSTUFF]     = bitstuff_err;
        err_set[`ERR_BUS_ADDR]     = bus_addr_err;
        err_set[`ERR_MEM_ACCESS]   = mem_access_err;
        err_set[`ERR_TURNAROUND]   = turnaround_timeout;
        err_set[`ERR_PARTIAL_BYTE] = partial_byte_err;
        err_set[`ERR_DATA_CRC]     = data_crc_err;
        // Shared position: source chosen by role
        err_set[`ERR_TOKEN_OR_EOF] = host_mode ? frame_end_err
                                               : token_crc_err;
        err_set[`ERR_PID_CHECK]    = pid_check_err;
    end

    assign err_clr = (write_phase && paddr == `OFS_ERROR_FLAGS) ? pwdata[7:0] : 8'h00;
    assign evt_clr = (write_phase && paddr == `OFS_EVENT_FLAGS) ? pwdata[7:0] : 8'h00;

    // Set wins over a same-cycle clear so no event is lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            usb_error_flags <= `REG_RESET;
        end else begin
            usb_error_flags <= (usb_error_flags & ~err_clr) | err_set;
        end
    end

    always_comb begin
        evt_set = event_pulse;
        evt_set[`EVT_TOKEN_DONE] = 1'b0;
        evt_set[`EVT_ERROR] = |(err_set & usb_error_enable);
    end

    // Token-done follows FIFO occupancy so it reasserts for queued entries
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            event_flags <= `REG_RESET;
        end else begin
            event_flags <= (event_flags & ~evt_clr) | evt_set;
            event_flags[`EVT_TOKEN_DONE] <= (fifo_count != 3'd0 && !fifo_pop)
                                            || fifo_count > 3'd1 || fifo_push;
        end
    end

    // Clearing token-done pops one entry; a full FIFO drops new status unless an entry is popped in the same cycle
    assign fifo_pop  = evt_clr[`EVT_TOKEN_DONE] && event_flags[`EVT_TOKEN_DONE];
    assign fifo_push = trans_done && (fifo_count < 3'(`STAT_FIFO_DEPTH) || fifo_pop);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ptr     <= 2'd0;
            wr_ptr     <= 2'd0;
            fifo_count <= 3'd0;
        end else begin
            if (fifo_push) begin
                wr_ptr <= wr_ptr + 2'd1;
            end
            if (fifo_pop) begin
                rd_ptr <= rd_ptr + 2'd1;
            end
            fifo_count <= fifo_count + {2'b00, fifo_push} - {2'b00, fifo_pop};
        end
    end

    always_ff @(posedge clk) begin
        if (fifo_push) begin
            fifo_mem[wr_ptr] <= '{trans_endpoint, trans_dir_tx, trans_bank_odd};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_fifo_full <= 1'b0;
        end else begin
            stat_fifo_full <= (fifo_count + {2'b00, fifo_push} - {2'b00, fifo_pop})
                              == 3'(`STAT_FIFO_DEPTH);
        end
    end

    // Bit 0 covers reset in device role, detach in host role: same position
    always_comb begin
        // Errors reach the request only through the summary flag, gated by bit 1
        next_irq_terms = event_flags & usb_event_enable;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            usb_irq_request <= 1'b0;
        end else begin
            usb_irq_request <= |next_irq_terms;
        end
    end

    property p_err_sticky;
        @(posedge clk) disable iff (!rst_n)
        usb_error_flags[`ERR_BITSTUFF] && !err_clr[`ERR_BITSTUFF]
        |=> usb_error_flags[`ERR_BITSTUFF];
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

    property p_bitstuff_set;
        @(posedge clk) disable iff (!rst_n)
        bitstuff_err |=> usb_error_flags[`ERR_BITSTUFF];
    endproperty
    a_bitstuff_set: assert property (p_bitstuff_set) else $error("bitstuff not set");

    property p_eof_host;
        @(posedge clk) disable iff (!rst_n)
        host_mode && frame_end_err |=> usb_error_flags[`ERR_TOKEN_OR_EOF];
    endproperty
    a_eof_host: assert property (p_eof_host) else $error("eof not set");

    property p_crc5_dev;
        @(posedge clk) disable iff (!rst_n)
        !host_mode && token_crc_err |=> usb_error_flags[`ERR_TOKEN_OR_EOF];
    endproperty
    a_crc5_dev: assert property (p_crc5_dev) else $error("crc5 not set");

    property p_err_gate;
        @(posedge clk) disable iff (!rst_n)
        !usb_event_enable[`EVT_ERROR] && (event_flags & usb_event_enable) == 8'h00
        |=> !usb_irq_request;
    endproperty
    a_err_gate: assert property (p_err_gate) else $error("ungated irq");

    property p_irq_or;
        @(posedge clk) disable iff (!rst_n)
        |(event_flags & usb_event_enable) |=> usb_irq_request;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq missing");

    property p_tok_valid;
        @(posedge clk) disable iff (!rst_n)
        event_flags[`EVT_TOKEN_DONE] |-> fifo_count != 3'd0;
    endproperty
    a_tok_valid: assert property (p_tok_valid) else $error("flag without status");

    property p_high_zero;
        @(posedge clk) disable iff (!rst_n)
        pready |-> prdata[31:8] == 24'h00_0000;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("upper bits set");

    property p_summary;
        @(posedge clk) disable iff (!rst_n)
        (err_set & usb_error_enable) != 8'h00 |=> event_flags[`EVT_ERROR];
    endproperty
    a_summary: assert property (p_summary) else $error("summary missing");

    property p_summary_gate;
        @(posedge clk) disable iff (!rst_n)
        !event_flags[`EVT_ERROR] && (err_set & usb_error_enable) == 8'h00
        |=> !event_flags[`EVT_ERROR];
    endproperty
    a_summary_gate: assert property (p_summary_gate) else $error("summary unmasked");

    // Register writes land only at the access edge
    property p_event_en_write;
        @(posedge clk) disable iff (!rst_n)
        write_phase && paddr == `OFS_EVENT_ENABLE |=> usb_event_enable == $past(pwdata[7:0]);
    endproperty
    a_event_en_write: assert property (p_event_en_write) else $error("enable write lost");

    property p_event_en_hold;
        @(posedge clk) disable iff (!rst_n)
        !(write_phase && paddr == `OFS_EVENT_ENABLE) |=> $stable(usb_event_enable);
    endproperty
    a_event_en_hold: assert property (p_event_en_hold) else $error("enable changed");

    property p_err_en_write;
        @(posedge clk) disable iff (!rst_n)
        write_phase && paddr == `OFS_ERROR_ENABLE |=> usb_error_enable == $past(pwdata[7:0]);
    endproperty
    a_err_en_write: assert property (p_err_en_write) else $error("err enable lost");

    property p_err_clear;
        @(posedge clk) disable iff (!rst_n)
        (err_clr & ~err_set) != 8'h00
        |=> (usb_error_flags & $past(err_clr & ~err_set)) == 8'h00;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("flag not cleared");

    // Each error source lands in its own flag one cycle later
    property p_bus_addr_set;
        @(posedge clk) disable iff (!rst_n)
        bus_addr_err |=> usb_error_flags[`ERR_BUS_ADDR];
    endproperty
    a_bus_addr_set: assert property (p_bus_addr_set) else $error("addr err not set");

    property p_mem_access_set;
        @(posedge clk) disable iff (!rst_n)
        mem_access_err |=> usb_error_flags[`ERR_MEM_ACCESS];
    endproperty
    a_mem_access_set: assert property (p_mem_access_set) else $error("mem err not set");

    property p_turnaround_set;
        @(posedge clk) disable iff (!rst_n)
        turnaround_timeout |=> usb_error_flags[`ERR_TURNAROUND];
    endproperty
    a_turnaround_set: assert property (p_turnaround_set) else $error("timeout not set");

    property p_partial_byte_set;
        @(posedge clk) disable iff (!rst_n)
        partial_byte_err |=> usb_error_flags[`ERR_PARTIAL_BYTE];
    endproperty
    a_partial_byte_set: assert property (p_partial_byte_set) else $error("size err");

    property p_data_crc_set;
        @(posedge clk) disable iff (!rst_n)
        data_crc_err |=> usb_error_flags[`ERR_DATA_CRC];
    endproperty
    a_data_crc_set: assert property (p_data_crc_set) else $error("crc16 not set");

    property p_pid_set;
        @(posedge clk) disable iff (!rst_n)
        pid_check_err |=> usb_error_flags[`ERR_PID_CHECK];
    endproperty
    a_pid_set: assert property (p_pid_set) else $error("pid err not set");

    // Status FIFO bookkeeping
    property p_pop_advance;
        @(posedge clk) disable iff (!rst_n)
        fifo_pop |=> rd_ptr == $past(rd_ptr) + 2'd1;
    endproperty
    a_pop_advance: assert property (p_pop_advance) else $error("fifo not advanced");

    property p_full_drop;
        @(posedge clk) disable iff (!rst_n)
        trans_done && fifo_count == 3'(`STAT_FIFO_DEPTH) && !fifo_pop
        |=> fifo_count == 3'(`STAT_FIFO_DEPTH);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("fifo overrun");

    // A second ready would complete a transfer the master never started
    property p_ready_pulse;
        @(posedge clk) disable iff (!rst_n)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready stuck");

    c_fifo_full: cover property (@(posedge clk) disable iff (!rst_n) stat_fifo_full);
    c_host_eof:  cover property (@(posedge clk) disable iff (!rst_n) host_mode && frame_end_err);
    c_pop:       cover property (@(posedge clk) disable iff (!rst_n) fifo_pop);
    c_irq:       cover property (@(posedge clk) disable iff (!rst_n) usb_irq_request);
    c_slverr:    cover property (@(posedge clk) disable iff (!rst_n) pslverr);

endmodule

`default_nettype wire

// File: rtl/usb_evt_consts.svh
`ifndef USB_EVT_CONSTS_SVH
`define USB_EVT_CONSTS_SVH

// Register byte offsets
`define OFS_EVENT_ENABLE   12'h000
`define OFS_ERROR_FLAGS    12'h004
`define OFS_ERROR_ENABLE   12'h008
`define OFS_TRANS_STATUS   12'h00C
`define OFS_EVENT_FLAGS    12'h010

// Event bit positions
`define EVT_STALL          3'd7
`define EVT_ATTACH         3'd6
`define EVT_RESUME         3'd5
`define EVT_IDLE           3'd4
`define EVT_TOKEN_DONE     3'd3
`define EVT_FRAME_START    3'd2
`define EVT_ERROR          3'd1
`define EVT_RESET_DETACH   3'd0

// Error bit positions
`define ERR_BITSTUFF       3'd7
`define ERR_BUS_ADDR       3'd6
`define ERR_MEM_ACCESS     3'd5
`define ERR_TURNAROUND     3'd4
`define ERR_PARTIAL_BYTE   3'd3
`define ERR_DATA_CRC       3'd2
`define ERR_TOKEN_OR_EOF   3'd1
`define ERR_PID_CHECK      3'd0

// Status field layout
`define STAT_EP_HI         7
`define STAT_EP_LO         4
`define STAT_DIR_BIT       3
`define STAT_BANK_BIT      2

`define REG_RESET          8'h00
`define STAT_FIFO_DEPTH    4
`define TURNAROUND_BITS    16

`endif

// File: rtl/usb_evt_pkg.sv
package usb_evt_pkg;
    typedef logic [7:0] reg8_t;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_READ,
        SEL_WRITE
    } apb_op_t;
    typedef struct packed {
        logic [3:0] endpoint;
        logic       dir_tx;
        logic       bank_odd;
    } stat_entry_t;
endpackage

// File: verification/usb_event_error_reporting_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_evt_consts.svh"

module usb_event_error_reporting_bench;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        host_mode;
    logic        irq;
    logic        full;
    logic [8:0]  errp;
    logic [7:0]  evtp;
    logic        done;
    logic [3:0]  ep;
    logic        dtx;
    logic        bodd;
    logic [31:0] r;
    logic        s;
    int          err_count;
    int          compares;
    int          cycles;
    int          b;
    int          evb[7] = '{7, 6, 5, 4, 2, 0, 0};

    usb_event_error_reporting i_usb_event_error_reporting (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_mode(host_mode), .event_pulse(evtp),
        .bitstuff_err(errp[7]), .bus_addr_err(errp[6]), .mem_access_err(errp[5]),
        .turnaround_timeout(errp[4]), .partial_byte_err(errp[3]), .data_crc_err(errp[2]),
        .token_crc_err(errp[1]), .frame_end_err(errp[8]), .pid_check_err(errp[0]),
        .trans_done(done), .trans_endpoint(ep), .trans_dir_tx(dtx),
        .trans_bank_odd(bodd), .usb_irq_request(irq), .stat_fifo_full(full));

    usb_far_side i_usb_far_side (.clk(clk), .err_pulse(errp), .evt_pulse(evtp),
        .done(done), .ep(ep), .dir_tx(dtx), .bank_odd(bodd));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Request is held until pready is sampled high; data is taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, r);
    endtask

    // The request output follows a flag by one cycle
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, host_mode, paddr, pwdata} = '0;
        err_count = 0;
        compares = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`OFS_EVENT_ENABLE, 32'h0, "event_en");
        rd(`OFS_ERROR_FLAGS, 32'h0, "err_flags");
        rd(`OFS_ERROR_ENABLE, 32'h0, "err_en");
        apb(1'b1, `OFS_EVENT_ENABLE, 32'hFFFFFFFF);
        rd(`OFS_EVENT_ENABLE, 32'h000000FF, "event_en");
        apb(1'b1, `OFS_ERROR_ENABLE, 32'hFFFFFF5A);
        rd(`OFS_ERROR_ENABLE, 32'h0000005A, "err_en");
        apb(1'b0, 12'h020, 32'h0);
        chk("slverr", 32'h1, {31'h0, s});
        apb(1'b1, `OFS_EVENT_ENABLE, 32'h0);
        apb(1'b1, `OFS_ERROR_ENABLE, 32'h0);
        for (int i = 0; i < 9; i++) begin
            host_mode <= (i == 8);
            b = (i == 8) ? 1 : i;
            i_usb_far_side.fault(i);
            rd(`OFS_ERROR_FLAGS, 32'h1 << b, "err_flags");
            rd(`OFS_ERROR_FLAGS, 32'h1 << b, "err_sticky");
            apb(1'b1, `OFS_ERROR_FLAGS, 32'h1 << b);
            rd(`OFS_ERROR_FLAGS, 32'h0, "err_cleared");
            irq_is(1'b0);
        end
        host_mode <= 1'b0;
        apb(1'b1, `OFS_ERROR_ENABLE, 32'h04);
        i_usb_far_side.fault(2);
        irq_is(1'b0);
        rd(`OFS_EVENT_FLAGS, 32'h02, "summary");
        apb(1'b1, `OFS_EVENT_ENABLE, 32'h02);
        irq_is(1'b1);
        apb(1'b1, `OFS_ERROR_FLAGS, 32'h04);
        apb(1'b1, `OFS_EVENT_FLAGS, 32'h02);
        irq_is(1'b0);
        i_usb_far_side.fault(0);
        rd(`OFS_EVENT_FLAGS, 32'h0, "summary");
        irq_is(1'b0);
        apb(1'b1, `OFS_ERROR_FLAGS, 32'h01);
        for (int k = 0; k < 7; k++) begin
            host_mode <= (k == 6);
            apb(1'b1, `OFS_EVENT_ENABLE, 32'hFF ^ (32'h1 << evb[k]));
            i_usb_far_side.event_seen(evb[k]);
            irq_is(1'b0);
            apb(1'b1, `OFS_EVENT_ENABLE, 32'h1 << evb[k]);
            irq_is(1'b1);
            apb(1'b1, `OFS_EVENT_FLAGS, 32'h1 << evb[k]);
            irq_is(1'b0);
        end
        host_mode <= 1'b0;
        apb(1'b1, `OFS_EVENT_ENABLE, 32'h08);
        for (int j = 0; j < 5; j++) begin
            i_usb_far_side.token(4'(j + 3), j[0], ~j[0]);
            if (j == 3) begin
                repeat (2) @(posedge clk);
                chk("fifo_full", 32'h1, {31'h0, full});
            end
        end
        irq_is(1'b1);
        for (int j = 0; j < 4; j++) begin
            rd(`OFS_TRANS_STATUS, {24'h0, 4'(j + 3), j[0], ~j[0], 2'b00}, "status");
            rd(`OFS_EVENT_FLAGS, 32'h08, "token_done");
            apb(1'b1, `OFS_EVENT_FLAGS, 32'h08);
            repeat (2) @(posedge clk);
        end
        rd(`OFS_EVENT_FLAGS, 32'h0, "token_done");
        chk("fifo_full", 32'h0, {31'h0, full});
        irq_is(1'b0);
        give_verdict();
    end
endmodule

`default_nettype wire

// File: verification/usb_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module usb_far_side (
    input  wire logic       clk,
    output logic      [8:0] err_pulse,
    output logic      [7:0] evt_pulse,
    output logic            done,
    output logic      [3:0] ep,
    output logic            dir_tx,
    output logic            bank_odd
);
    initial begin
        err_pulse = 9'h000;
        evt_pulse = 8'h00;
        done = 1'b0;
        {ep, dir_tx, bank_odd} = 6'h00;
    end

    // Bit 8 stands for the end-of-frame error, which shares flag bit 1 in host role
    task automatic fault(input int i);
        @(posedge clk);
        err_pulse[i] <= 1'b1;
        @(posedge clk);
        err_pulse[i] <= 1'b0;
    endtask

    task automatic event_seen(input int i);
        @(posedge clk);
        evt_pulse[i] <= 1'b1;
        @(posedge clk);
        evt_pulse[i] <= 1'b0;
    endtask

    // Fields are scrambled once the strobe drops so nothing latches stale values
    task automatic token(input logic [3:0] e, input logic d, input logic b);
        @(posedge clk);
        done <= 1'b1;
        {ep, dir_tx, bank_odd} <= {e, d, b};
        @(posedge clk);
        done <= 1'b0;
        {ep, dir_tx, bank_odd} <= ~{e, d, b};
    endtask
endmodule

`default_nettype wire
